/* verilog/ascii_frame_cfg.svh */
// Character codes, frame positions, lengths and error codes of the ASCII drive frame checker.
`ifndef ASCII_FRAME_CFG_SVH
`define ASCII_FRAME_CFG_SVH

// ----------------------------------------------------------------------------
// Character codes and the broadcast address
// ----------------------------------------------------------------------------
`define CH_SOH      8'h01
`define CH_ETX      8'h03
`define CH_ENQ      8'h05
`define CH_ACK      8'h06
`define CH_NAK      8'h15
`define CH_SP       8'h20
`define CH_CMD_R    8'h52
`define BCAST_ADDR  16'h3939

// ----------------------------------------------------------------------------
// Frame positions and lengths
// ----------------------------------------------------------------------------
`define POS_ENQ     4'h3
`define POS_CMD     4'h4
`define POS_ETX_STD 4'hD
`define POS_ETX_OPT 4'h9
`define POS_LAST    4'hF
`define LEN_STD     5'h10
`define LEN_POLL    5'h0C
`define LEN_SEL     5'h08
`define DATA_STD    4'h9
`define DATA_OPT    4'h5

// ----------------------------------------------------------------------------
// Error codes and reset values
// ----------------------------------------------------------------------------
`define ERR_FORMAT  8'h4A
`define ERR_COMMAND 8'h4B
`define ERR_RESET   8'h00

`endif

/* verilog/ascii_frame_pkg.sv */
// Types and character helpers shared by the ASCII drive frame checker.
package ascii_frame_pkg;

    typedef enum logic [1:0] {
        CLS_STD  = 2'h0,
        CLS_SEL  = 2'h1,
        CLS_POLL = 2'h2,
        CLS_BAD  = 2'h3
    } cmd_cls_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h0,
        TX_BODY = 2'h1,
        TX_SUM  = 2'h3,
        TX_LAST = 2'h2
    } tx_state_t;

    typedef struct packed {
        logic [7:0]  cmd;
        logic [7:0]  grp;
        logic [15:0] num;
        logic [15:0] data;
    } req_t;

    // Digits above nine always come out as upper-case letters.
    function automatic logic [7:0] hex_ascii(input logic [3:0] n);
        hex_ascii = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    function automatic logic [3:0] hex_val(input logic [7:0] c);
        hex_val = (c >= 8'h41) ? 4'(c[3:0] + 4'h9) : c[3:0];
    endfunction

    function automatic cmd_cls_t classify(input logic [7:0] c);
        case (c)
            8'h52, 8'h57, 8'h41, 8'h45:        classify = CLS_STD;
            8'h61, 8'h65, 8'h66, 8'h6D:        classify = CLS_SEL;
            8'h67, 8'h68, 8'h69, 8'h6A, 8'h6B: classify = CLS_POLL;
            default:                           classify = CLS_BAD;
        endcase
    endfunction

endpackage

/* verilog/checksum_hex_pair.sv */
// Running byte checksum with its low byte presented as two ASCII hex digits.
module checksum_hex_pair
    import ascii_frame_pkg::*;
(
    // Clock and control
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic       ce_i,
    // Accumulation
    input  wire logic       clr_i,
    input  wire logic       add_i,
    input  wire logic [7:0] byte_i,
    // Digits of the sum including this cycle's byte
    output logic      [7:0] hi_o,
    output logic      [7:0] lo_o
);

    logic [7:0] sum_r;
    logic [7:0] sum_nxt;

    // Only the low byte of the sum is kept; carries fall off.
    always_comb begin
        sum_nxt = sum_r;
        if (clr_i) begin
            sum_nxt = 8'h00;
        end else if (add_i) begin
            sum_nxt = 8'(sum_r + byte_i);
        end
        hi_o = hex_ascii(sum_nxt[7:4]);
        lo_o = hex_ascii(sum_nxt[3:0]);
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            sum_r <= 8'h00;
        end else if (ce_i) begin
            sum_r <= sum_nxt;
        end
    end

endmodule

/* verilog/ascii_drive_frame_checker.sv */
// Receive checker and reply former for the ASCII master/slave drive protocol.
`include "ascii_frame_cfg.svh"
module ascii_drive_frame_checker
    import ascii_frame_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        ce_i,
    // Received characters
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_byte_i,
    // Own station address as two ASCII digits
    input  wire logic [15:0] station_i,
    // Data reported by read replies
    input  wire logic [15:0] rd_data_i,
    // Reply characters
    input  wire logic        tx_ready_i,
    output logic             tx_valid_o,
    output logic      [7:0]  tx_byte_o,
    // Accepted requests
    output logic             req_valid_o,
    output req_t             req_o,
    // Last recorded communications error
    output logic      [7:0]  comm_error_code_monitor_o
);

    // ------------------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------------------
    logic [3:0]  pos_r, pos_nxt;
    logic        active_r, active_nxt;
    logic        etx_r, etx_nxt;
    logic        hi_ok_r, hi_ok_nxt;
    cmd_cls_t    cls_r, cls_nxt;
    logic [7:0]  rbuf_r [16];
    logic [7:0]  rbuf_nxt [16];
    logic        pend_r, pend_nxt;
    logic        pend_nak_r, pend_nak_nxt;
    logic        pend_rd_r, pend_rd_nxt;
    logic [4:0]  pend_len_r, pend_len_nxt;
    logic [7:0]  err_r, err_nxt;
    logic        req_valid_r, req_valid_nxt;
    req_t        req_r, req_nxt;
    tx_state_t   txs_r;
    logic        rx_take, to_us, bcast, rx_clr, rx_add;
    logic [3:0]  etx_pos;
    logic [7:0]  rx_hi, rx_lo;

    assign rx_take = rx_valid_i && !pend_r && txs_r == TX_IDLE;
    assign to_us   = {rbuf_r[1], rbuf_r[2]} == station_i;
    assign bcast   = {rbuf_r[1], rbuf_r[2]} == `BCAST_ADDR;
    assign etx_pos = (cls_r == CLS_STD) ? `POS_ETX_STD : `POS_ETX_OPT;
    assign rx_clr  = rx_take && rx_byte_i == `CH_SOH;
    assign rx_add  = rx_take && active_r && !etx_r && !rx_clr;

    checksum_hex_pair u_rx_sum (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .clr_i     (rx_clr),
        .add_i     (rx_add),
        .byte_i    (rx_byte_i),
        .hi_o      (rx_hi),
        .lo_o      (rx_lo)
    );

    always_comb begin
        pos_nxt       = pos_r;
        active_nxt    = active_r;
        etx_nxt       = etx_r;
        hi_ok_nxt     = hi_ok_r;
        cls_nxt       = cls_r;
        rbuf_nxt      = rbuf_r;
        pend_nxt      = pend_r && txs_r != TX_IDLE;
        pend_nak_nxt  = pend_nak_r;
        pend_rd_nxt   = pend_rd_r;
        pend_len_nxt  = pend_len_r;
        err_nxt       = err_r;
        req_valid_nxt = 1'b0;
        req_nxt       = req_r;
        if (rx_clr) begin
            pos_nxt    = 4'h1;
            active_nxt = 1'b1;
            etx_nxt    = 1'b0;
        end else if (rx_take && active_r) begin
            rbuf_nxt[pos_r] = rx_byte_i;
            pos_nxt         = 4'(pos_r + 4'h1);
            if (pos_r == `POS_ENQ && rx_byte_i != `CH_ENQ) begin
                active_nxt = 1'b0;
                if (to_us) begin
                    pend_nxt     = 1'b1;
                    pend_nak_nxt = 1'b1;
                    pend_len_nxt = `LEN_STD;
                    err_nxt      = `ERR_FORMAT;
                end
            end else if (pos_r == `POS_CMD) begin
                cls_nxt = classify(rx_byte_i);
                if (cls_nxt == CLS_BAD) begin
                    active_nxt = 1'b0;
                    if (to_us) begin
                        pend_nxt     = 1'b1;
                        pend_nak_nxt = 1'b1;
                        pend_len_nxt = `LEN_STD;
                        err_nxt      = `ERR_COMMAND;
                    end
                end
            end else if (!etx_r && pos_r == etx_pos && rx_byte_i == `CH_ETX) begin
                etx_nxt = 1'b1;
            end else if (!etx_r && pos_r == etx_pos && cls_r != CLS_STD) begin
                active_nxt = 1'b0;
                if (to_us) begin
                    pend_nxt     = 1'b1;
                    pend_nak_nxt = 1'b1;
                    pend_len_nxt = (cls_r == CLS_SEL) ? `LEN_SEL : `LEN_POLL;
                    pend_rd_nxt  = cls_r == CLS_POLL;
                    err_nxt      = `ERR_FORMAT;
                end
            end else if (!etx_r && pos_r == `POS_LAST) begin
                active_nxt = 1'b0;
            end else if (etx_r && pos_r == 4'(etx_pos + 4'h1)) begin
                hi_ok_nxt = rx_byte_i == rx_hi;
            end else if (etx_r) begin
                active_nxt = 1'b0;
                if (hi_ok_r && rx_byte_i == rx_lo && (to_us || bcast)) begin
                    req_valid_nxt = 1'b1;
                    req_nxt.cmd   = rbuf_r[4];
                    req_nxt.grp   = (cls_r == CLS_STD) ? rbuf_r[5] : 8'h00;
                    req_nxt.num   = (cls_r == CLS_STD) ? {rbuf_r[6], rbuf_r[7]} : 16'h0000;
                    for (int i = 0; i < 4; i++) begin
                        req_nxt.data[15 - 4 * i -: 4] =
                            hex_val(rbuf_r[int'(etx_pos) - 4 + i]);
                    end
                    if (!bcast) begin
                        pend_nxt     = 1'b1;
                        pend_nak_nxt = 1'b0;
                        pend_rd_nxt  = cls_r == CLS_POLL || rbuf_r[4] == `CH_CMD_R;
                        pend_len_nxt = (cls_r == CLS_STD) ? `LEN_STD :
                                       (cls_r == CLS_SEL) ? `LEN_SEL : `LEN_POLL;
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pos_r       <= 4'h0;
            active_r    <= 1'b0;
            etx_r       <= 1'b0;
            hi_ok_r     <= 1'b0;
            cls_r       <= CLS_STD;
            rbuf_r      <= '{default: 8'h00};
            pend_r      <= 1'b0;
            pend_nak_r  <= 1'b0;
            pend_rd_r   <= 1'b0;
            pend_len_r  <= `LEN_STD;
            err_r       <= `ERR_RESET;
            req_valid_r <= 1'b0;
            req_r       <= '0;
        end else if (ce_i) begin
            pos_r       <= pos_nxt;
            active_r    <= active_nxt;
            etx_r       <= etx_nxt;
            hi_ok_r     <= hi_ok_nxt;
            cls_r       <= cls_nxt;
            rbuf_r      <= rbuf_nxt;
            pend_r      <= pend_nxt;
            pend_nak_r  <= pend_nak_nxt;
            pend_rd_r   <= pend_rd_nxt;
            pend_len_r  <= pend_len_nxt;
            err_r       <= err_nxt;
            req_valid_r <= req_valid_nxt;
            req_r       <= req_nxt;
        end
    end

    assign req_valid_o               = req_valid_r;
    assign req_o                     = req_r;
    assign comm_error_code_monitor_o = err_r;

    // ------------------------------------------------------------------------
    // Reply side
    // ------------------------------------------------------------------------
    // The reply is formed one cycle after the decision so that rd_data_i can
    // answer the request that req_valid_o announced.
    logic [7:0]  tbuf_r [16];
    logic [7:0]  tbuf_nxt [16];
    logic [4:0]  tlen_r, tlen_nxt;
    logic [3:0]  tidx_r, tidx_nxt;
    tx_state_t   txs_nxt;
    logic        tv_r, tv_nxt;
    logic [7:0]  tb_r, tb_nxt;
    logic        fill, hs;
    logic [3:0]  db;
    logic [7:0]  tx_hi, tx_lo;
    logic [7:0]  dfield [4];

    assign fill = pend_r && txs_r == TX_IDLE;
    assign hs   = tv_r && tx_ready_i;
    assign db   = (pend_len_r == `LEN_STD) ? `DATA_STD : `DATA_OPT;

    checksum_hex_pair u_tx_sum (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .clr_i     (fill),
        .add_i     (hs && txs_r == TX_BODY && tidx_r != 4'h0),
        .byte_i    (tb_r),
        .hi_o      (tx_hi),
        .lo_o      (tx_lo)
    );

    always_comb begin
        tbuf_nxt = tbuf_r;
        tlen_nxt = tlen_r;
        tidx_nxt = tidx_r;
        txs_nxt  = txs_r;
        tv_nxt   = tv_r;
        tb_nxt   = tb_r;
        for (int i = 0; i < 4; i++) begin
            if (pend_nak_r) begin
                dfield[i] = (i < 2) ? `CH_SP : hex_ascii(err_r[7 - 4 * (i % 2) -: 4]);
            end else if (pend_rd_r) begin
                dfield[i] = hex_ascii(rd_data_i[15 - 4 * i -: 4]);
            end else begin
                dfield[i] = rbuf_r[int'(db) + i];
            end
        end
        if (fill) begin
            tbuf_nxt    = '{default: `CH_SP};
            tbuf_nxt[0] = `CH_SOH;
            tbuf_nxt[1] = rbuf_r[1];
            tbuf_nxt[2] = rbuf_r[2];
            tbuf_nxt[3] = pend_nak_r ? `CH_NAK : `CH_ACK;
            tbuf_nxt[4] = rbuf_r[4];
            if (pend_len_r == `LEN_STD) begin
                for (int i = 5; i < 8; i++) begin
                    tbuf_nxt[i] = rbuf_r[i];
                end
                tbuf_nxt[8] = pend_nak_r ? `CH_SP : rbuf_r[8];
            end
            if (pend_len_r == `LEN_SEL) begin
                tbuf_nxt[5] = `CH_ETX;
            end else begin
                for (int i = 0; i < 4; i++) begin
                    tbuf_nxt[int'(db) + i] = dfield[i];
                end
                tbuf_nxt[4'(db + 4'h4)] = `CH_ETX;
            end
            tlen_nxt = pend_len_r;
            tidx_nxt = 4'h0;
            txs_nxt  = TX_BODY;
            tv_nxt   = 1'b1;
            tb_nxt   = `CH_SOH;
        end else if (hs) begin
            case (txs_r)
                TX_BODY: begin
                    if ({1'b0, tidx_r} == 5'(tlen_r - 5'h3)) begin
                        txs_nxt = TX_SUM;
                        tb_nxt  = tx_hi;
                    end else begin
                        tidx_nxt = 4'(tidx_r + 4'h1);
                        tb_nxt   = tbuf_r[tidx_nxt];
                    end
                end
                TX_SUM: begin
                    txs_nxt = TX_LAST;
                    tb_nxt  = tx_lo;
                end
                TX_LAST: begin
                    txs_nxt = TX_IDLE;
                    tv_nxt  = 1'b0;
                end
                default: begin
                    txs_nxt = TX_IDLE;
                    tv_nxt  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            tbuf_r <= '{default: 8'h00};
            tlen_r <= `LEN_STD;
            tidx_r <= 4'h0;
            txs_r  <= TX_IDLE;
            tv_r   <= 1'b0;
            tb_r   <= 8'h00;
        end else if (ce_i) begin
            tbuf_r <= tbuf_nxt;
            tlen_r <= tlen_nxt;
            tidx_r <= tidx_nxt;
            txs_r  <= txs_nxt;
            tv_r   <= tv_nxt;
            tb_r   <= tb_nxt;
        end
    end

    assign tx_valid_o = tv_r;
    assign tx_byte_o  = tb_r;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    a_enq_missing: assert property (ce_i && rx_take && active_r && !rx_clr
        && pos_r == `POS_ENQ && rx_byte_i != `CH_ENQ && to_us |=> pend_r && pend_nak_r
        && pend_len_r == `LEN_STD && err_r == `ERR_FORMAT)
        else $error("missing ENQ not answered");
    a_cmd_unknown: assert property (ce_i && rx_take && active_r && !rx_clr
        && pos_r == `POS_CMD && classify(rx_byte_i) == CLS_BAD && to_us
        |=> pend_r && err_r == `ERR_COMMAND && pend_len_r == `LEN_STD)
        else $error("unknown command not answered");
    a_etx_missing: assert property (ce_i && rx_take && !rx_clr && active_r && !etx_r
        && pos_r == `POS_ETX_OPT && cls_r == CLS_SEL && rx_byte_i != `CH_ETX && to_us
        |=> pend_len_r == `LEN_SEL && err_r == `ERR_FORMAT)
        else $error("missing ETX not answered");
    a_no_etx_drop: assert property (ce_i && rx_take && !rx_clr && active_r && !etx_r
        && pos_r == `POS_LAST && !pend_r |=> !active_r && !pend_r)
        else $error("frame without ETX answered");
    a_bcast_quiet: assert property (ce_i && req_valid_nxt && bcast |=> !pend_r)
        else $error("broadcast answered");
    a_soh_restart: assert property (ce_i && rx_clr |=> pos_r == 4'h1 && active_r)
        else $error("SOH did not restart position");
    a_sum_upper: assert property (tv_r && (txs_r == TX_SUM || txs_r == TX_LAST) |->
        (tb_r inside {[8'h30:8'h39], [8'h41:8'h46]})) else $error("bad checksum digit");
    a_reply_start: assert property ($rose(tv_r) |-> tb_r == `CH_SOH ##1 !$rose(tv_r))
        else $error("reply does not open with SOH");
    a_reply_len: assert property (hs && txs_r == TX_BODY && txs_nxt == TX_SUM && ce_i |->
        tb_r == `CH_ETX && 5'(tidx_r + 5'h3) == tlen_r) else $error("reply length wrong");

    c_std_ack: cover property (fill && !pend_nak_r && pend_len_r == `LEN_STD);
    c_poll_nak: cover property (fill && pend_nak_r && pend_len_r == `LEN_POLL);
    c_sel_ack: cover property (fill && !pend_nak_r && pend_len_r == `LEN_SEL);
    c_bcast_req: cover property (req_valid_r && !pend_r);

endmodule

/* test/host_model.sv */
// Host model that sends request frames and gathers the block's reply characters.
module host_model (
    // Clock
    input  wire logic       sys_clk_i,
    // Request characters towards the block
    output logic            rx_valid_o,
    output logic      [7:0] rx_byte_o,
    // Reply characters from the block
    output logic            tx_ready_o,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_byte_i
);
    timeunit 1ns;
    timeprecision 1ps;

    typedef logic [7:0] q8_t [$];

    logic       slow;
    logic [7:0] reply [$];

    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o  = 8'hFF;
        slow       = 1'b0;
    end

    function automatic logic [7:0] hx(input logic [3:0] n);
        return (n > 4'h9) ? 8'h37 + {4'h0, n} : 8'h30 + {4'h0, n};
    endfunction

    function automatic q8_t raw(input logic [7:0] c, input string a, input string b);
        q8_t f;
        f.push_back(8'h01);
        f.push_back(a[0]);
        f.push_back(a[1]);
        f.push_back(c);
        for (int i = 0; i < b.len(); i++) f.push_back(b[i]);
        return f;
    endfunction

    function automatic q8_t mk(input logic [7:0] c, input string a, input string b);
        q8_t        f;
        logic [7:0] s;
        f = raw(c, a, b);
        f.push_back(8'h03);
        s = 8'h00;
        foreach (f[i]) s += (i > 0) ? f[i] : 8'h00;
        f.push_back(hx(s[7:4]));
        f.push_back(hx(s[3:0]));
        return f;
    endfunction

    // After the frame the line shows the inverse of the last character, so stale data never passes.
    task automatic send(input logic [7:0] f [$]);
        foreach (f[i]) begin
            @(negedge sys_clk_i);
            rx_valid_o = 1'b1;
            rx_byte_o  = f[i];
        end
        @(negedge sys_clk_i);
        rx_valid_o = 1'b0;
        rx_byte_o  = ~rx_byte_o;
    endtask

    // A slow host takes a reply character only every other cycle.
    always @(negedge sys_clk_i) begin
        tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
    end

    always @(posedge sys_clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            reply.push_back(tx_byte_i);
        end
    end
endmodule

/* test/test_ascii_drive_frame_checker.sv */
// Self-checking testbench of the ASCII drive frame checker.
module test_ascii_drive_frame_checker;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  sys_clk_i;
    logic                  sys_rst_i;
    logic                  ce_i;
    logic                  rx_valid;
    logic [7:0]            rx_byte;
    logic [15:0]           station;
    logic [15:0]           rd_data;
    logic                  tx_ready;
    logic                  tx_valid;
    logic [7:0]            tx_byte;
    logic                  req_valid;
    ascii_frame_pkg::req_t req;
    logic [7:0]            err_code;
    int                    mismatches;
    int                    compares;
    int                    req_seen;
    logic [7:0]            f [$];
    logic [7:0]            e [$];

    ascii_drive_frame_checker dut (
        .sys_clk_i                 (sys_clk_i),
        .sys_rst_i                 (sys_rst_i),
        .ce_i                      (ce_i),
        .rx_valid_i                (rx_valid),
        .rx_byte_i                 (rx_byte),
        .station_i                 (station),
        .rd_data_i                 (rd_data),
        .tx_ready_i                (tx_ready),
        .tx_valid_o                (tx_valid),
        .tx_byte_o                 (tx_byte),
        .req_valid_o               (req_valid),
        .req_o                     (req),
        .comm_error_code_monitor_o (err_code)
    );

    host_model host (
        .sys_clk_i  (sys_clk_i),
        .rx_valid_o (rx_valid),
        .rx_byte_o  (rx_byte),
        .tx_ready_o (tx_ready),
        .tx_valid_i (tx_valid),
        .tx_byte_i  (tx_byte)
    );

    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end

    always @(posedge sys_clk_i) begin
        if (req_valid === 1'b1) begin
            req_seen++;
        end
    end

    // ------------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------------
    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // The quiet stretch after each reply also catches any extra characters.
    task automatic xfer(input int n);
        int w;
        host.reply.delete();
        host.send(f);
        for (w = 0; w < 400 && host.reply.size() < n; w++) @(posedge sys_clk_i);
        if (w == 400) begin
            mismatches++;
            $display("[FAIL] %0t reply wait ran out", $time);
            report_and_stop();
        end
        repeat (40) @(negedge sys_clk_i);
        check(host.reply.size(), n, "reply length");
    endtask

    task automatic same(input string what);
        foreach (e[i]) check((i < host.reply.size()) ? host.reply[i] : 8'hXX, e[i], what);
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_std();
        string s = "WAE";
        host.slow = 1'b1;
        rd_data   = 16'h0BB8;
        for (int i = 0; i < s.len(); i++) begin
            f = host.mk(8'h05, "12", $sformatf("%cS02 0FA0", s[i]));
            e = host.mk(8'h06, "12", $sformatf("%cS02 0FA0", s[i]));
            xfer(16);
            same("write ack");
            check(req.cmd, s[i], "write command");
            check(req.data, 16'h0FA0, "write data");
        end
        f = host.mk(8'h05, "12", "RM10 0000");
        e = host.mk(8'h06, "12", "RM10 0BB8");
        xfer(16);
        same("read ack");
        check({req.grp, req.num}, 24'h4D3130, "read function code");
        host.slow = 1'b0;
        $display("Standard frame test done");
    endtask

    task automatic t_opt();
        string s = "aefm";
        string p = "ghijk";
        rd_data = 16'hE5F5;
        for (int i = 0; i < s.len(); i++) begin
            f = host.mk(8'h05, "12", $sformatf("%c0001", s[i]));
            e = host.mk(8'h06, "12", $sformatf("%c", s[i]));
            xfer(8);
            same("select ack");
            check(req.data, 16'h0001, "select data");
            check({req.grp, req.num}, 24'h000000, "select code fields");
        end
        for (int i = 0; i < p.len(); i++) begin
            f = host.mk(8'h05, "12", $sformatf("%c0000", p[i]));
            e = host.mk(8'h06, "12", $sformatf("%cE5F5", p[i]));
            xfer(12);
            same("poll ack");
        end
        $display("Optional frame test done");
    endtask

    // Command, group and number fields of these replies may hold anything.
    task automatic std_nak(input logic [7:0] c);
        logic [7:0] s;
        s = 8'h00;
        xfer(16);
        for (int i = 1; i < 14 && i < host.reply.size(); i++) s += host.reply[i];
        check(host.reply[3], 8'h15, "nak character");
        check({host.reply[11], host.reply[12]}, {host.hx(c[7:4]), host.hx(c[3:0])}, "digits");
        check({host.reply[14], host.reply[15]}, {host.hx(s[7:4]), host.hx(s[3:0])}, "sum");
        check(err_code, c, "error code");
    endtask

    task automatic t_nak();
        check(err_code, 8'h00, "error code after reset");
        f = host.raw(8'h05, "12", "f0001X");
        e = host.mk(8'h15, "12", "f");
        xfer(8);
        same("select nak");
        check(err_code, 8'h4A, "format code");
        f = host.raw(8'h05, "12", "j0000X");
        e = host.mk(8'h15, "12", "j  4A");
        xfer(12);
        same("poll nak");
        f = host.raw(8'h05, "12", "Z");
        std_nak(8'h4B);
        f = host.raw(8'h58, "12", "");
        std_nak(8'h4A);
        $display("Negative acknowledge test done");
    endtask

    task automatic t_silent();
        int n;
        f = host.raw(8'h05, "12", "WS02 0FA0XXX");
        xfer(0);
        f = host.mk(8'h05, "21", "WS02 0FA0");
        xfer(0);
        f = host.mk(8'h05, "12", "WS02 0FA0");
        f[15] = f[15] ^ 8'h01;
        xfer(0);
        n = req_seen;
        f = host.mk(8'h05, "99", "f0002");
        xfer(0);
        check(req_seen, n + 1, "broadcast delivered");
        f = host.raw(8'h05, "12", "WS");
        e = host.mk(8'h05, "12", "WS02 0FA0");
        f = {f, e};
        e = host.mk(8'h06, "12", "WS02 0FA0");
        xfer(16);
        same("restarted ack");
        // A frozen block must neither take the frame nor answer it.
        ce_i = 1'b0;
        n    = req_seen;
        f    = host.mk(8'h05, "12", "f0001");
        xfer(0);
        check(req_seen, n, "frozen request");
        ce_i = 1'b1;
        $display("Silent drop test done");
    endtask

    initial begin
        sys_rst_i = 1'b1;
        ce_i      = 1'b1;
        station   = 16'h3132;
        rd_data   = 16'h0000;
        repeat (20) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        t_nak();
        t_std();
        t_opt();
        t_silent();
        report_and_stop();
    end
endmodule
